// ### hdl/bmm_pkg.sv
// Package for the banked memory map: widths, vectors, address regions and carriers
package bmm_pkg;
  localparam int PC_W = 13;
  localparam int IMPL_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] INT_VEC = 13'h0004;
  localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
  localparam logic [6:0] OFS_PCL = 7'h02;
  localparam logic [6:0] OFS_FLAGS = 7'h03;
  localparam logic [6:0] OFS_PTR = 7'h04;
  localparam logic [6:0] OFS_PROGRAM_COUNTER_HIGH_LATCH = 7'h0A;
  localparam logic [6:0] SFR_TOP = 7'h1F;
  localparam logic [7:0] RAM0_LO = 8'h20;
  localparam logic [7:0] RAM0_HI = 8'h7F;
  localparam logic [7:0] RAM1_LO = 8'hA0;
  localparam logic [7:0] RAM1_HI = 8'hBF;
  localparam logic [7:0] MIR_LO = 8'hF0;
  localparam logic [7:0] MIR_OFS = 8'h80;
  localparam int RAM_DEPTH = 128;
  localparam int BANK_BIT = 5;
  localparam int RSV_BANK_BIT = 6;
  localparam int RSV_PAGE_BIT = 7;
  localparam logic [7:0] FLAGS_RST = 8'h18;
  localparam logic [7:0] FLAGS_WMASK = 8'hE7;
  localparam logic [4:0] PROGRAM_COUNTER_HIGH_LATCH_RST = 5'h00;

  typedef enum logic [1:0] {
    BMM_PC_NEXT = 2'b00,
    BMM_PC_JUMP = 2'b01,
    BMM_PC_CALL = 2'b10,
    BMM_PC_RET = 2'b11
  } bmm_pc_op_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic indirect;
    logic [6:0] addr;
    logic [7:0] wdata;
  } bmm_dreq_t;
endpackage

// ### hdl/bmm_top.sv
// Program counter, return stack and banked data memory decoder
//
// Function
// - The program counter is thirteen bits wide, covering eight thousand instruction words.
// - Fetch addresses above the lowest two thousand words wrap into that implemented range.
// - Fetching starts at address zero after reset and an accepted interrupt vectors to address four.
// - An eight-entry hardware stack keeps return addresses for calls and interrupts.
// - Data memory has two banks whose first thirty-two locations are special function registers.
// - General purpose RAM sits at 20h-7Fh of bank zero and A0h-BFh of bank one.
// - Locations F0h-FFh in bank one reach the same storage as 70h-7Fh of bank zero.
// - Every other location is unimplemented and reads zero.
// - The bank select bit of the flags register picks the bank for direct addressing.
// - The 128 x 8 register file is reached directly or through the indirect pointer.
// - Bank select set maps direct accesses to 80h-FFh, clear maps them to 00h-7Fh.
`timescale 1ns/1ns
module bmm_top (
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire bmm_pkg::bmm_pc_op_t pc_op, // Program counter operation this cycle
  input wire logic [bmm_pkg::PC_W-1:0] pc_target, // Jump or call target
  input wire logic int_take, // Interrupt accepted, push and vector
  input wire bmm_pkg::bmm_dreq_t dreq, // Data access request
  output logic [bmm_pkg::PC_W-1:0] pc, // Program counter
  output logic [bmm_pkg::IMPL_W-1:0] fetch_addr, // Physical fetch address
  output logic [7:0] rdata, // Read data, valid cycle after request
  output logic [7:0] flags, // Processor flags register
  output logic [7:0] sfr_addr, // Full decoded address of a peripheral register access
  output logic sfr_sel, // Access goes to a special function register location, including the core registers held in this block
  output logic stack_full // All stack entries hold return addresses
);
  import bmm_pkg::*;

  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [SP_W:0] depth_q;
  logic [7:0] ram_q [RAM_DEPTH];
  logic [7:0] flags_q;
  logic [7:0] ptr_q;
  logic [4:0] program_counter_high_latch_q;
  logic [7:0] rdata_q;
  logic [7:0] full_addr;
  logic is_ram;
  logic [6:0] ram_idx;
  logic is_sfr;

  // Folds a data address onto the shared RAM index, or flags it absent
  function automatic logic [7:0] ram_map(input logic [7:0] a);
    logic [7:0] r;
    r = 8'hFF;
    if (a >= RAM0_LO && a <= RAM0_HI) begin
      r = {1'b0, a[6:0]};
    end else if (a >= RAM1_LO && a <= RAM1_HI) begin
      r = a - RAM1_LO + MIR_OFS;
    end else if (a >= MIR_LO) begin
      r = a - MIR_OFS;
    end
    return r;
  endfunction

  // Direct address takes the bank bit on top, indirect uses the whole pointer
  always_comb begin
    if (dreq.indirect || dreq.addr == OFS_INDIRECT_DATA_PORT) begin
      full_addr = ptr_q;
    end else begin
      full_addr = {flags_q[BANK_BIT], dreq.addr};
    end
  end

  logic [7:0] map_v;
  assign map_v = ram_map(full_addr);
  assign is_ram = (map_v != 8'hFF);
  assign ram_idx = map_v[6:0];
  assign is_sfr = (full_addr[6:0] <= SFR_TOP);

  // Program counter with reset and interrupt vectors
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= RESET_VEC;
    end else if (int_take) begin
      pc_q <= INT_VEC;
    end else if (dreq.valid && dreq.write && is_sfr && full_addr[6:0] == OFS_PCL) begin
      pc_q <= {program_counter_high_latch_q, dreq.wdata};
    end else begin
      unique case (pc_op)
        BMM_PC_NEXT: pc_q <= pc_q + 13'h0001;
        BMM_PC_JUMP: pc_q <= pc_target;
        BMM_PC_CALL: pc_q <= pc_target;
        BMM_PC_RET: pc_q <= stack_q[sp_q - 3'h1];
      endcase
    end
  end

  // Circular return stack: overflow overwrites the oldest entry
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= '0;
      depth_q <= '0;
    end else if (int_take || pc_op == BMM_PC_CALL) begin
      sp_q <= sp_q + 3'h1;
      if (depth_q != 4'(STACK_DEPTH)) depth_q <= depth_q + 4'h1;
    end else if (pc_op == BMM_PC_RET) begin
      sp_q <= sp_q - 3'h1;
      if (depth_q != 4'h0) depth_q <= depth_q - 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (int_take) begin
      stack_q[sp_q] <= (pc_op == BMM_PC_NEXT) ? pc_q + 13'h0001 : pc_target;
    end else if (pc_op == BMM_PC_CALL) begin
      stack_q[sp_q] <= pc_q + 13'h0001;
    end
  end

  // Core registers; reserved bits are stored as written, software keeps them clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RST;
      ptr_q <= '0;
      program_counter_high_latch_q <= PROGRAM_COUNTER_HIGH_LATCH_RST;
    end else if (dreq.valid && dreq.write && is_sfr) begin
      unique case (full_addr[6:0])
        OFS_FLAGS: flags_q <= (flags_q & ~FLAGS_WMASK) | (dreq.wdata & FLAGS_WMASK);
        OFS_PTR: ptr_q <= dreq.wdata;
        OFS_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_q <= dreq.wdata[4:0];
        default: ;
      endcase
    end
  end

  // Shared general purpose RAM
  always_ff @(posedge sys_clk) begin
    if (dreq.valid && dreq.write && is_ram) begin
      ram_q[ram_idx] <= dreq.wdata;
    end
  end

  // Registered read data; unimplemented locations read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (dreq.valid && !dreq.write) begin
      if (is_ram) begin
        rdata_q <= ram_q[ram_idx];
      end else if (is_sfr) begin
        unique case (full_addr[6:0])
          OFS_PCL: rdata_q <= pc_q[7:0];
          OFS_FLAGS: rdata_q <= flags_q;
          OFS_PTR: rdata_q <= ptr_q;
          OFS_PROGRAM_COUNTER_HIGH_LATCH: rdata_q <= {3'h0, program_counter_high_latch_q};
          default: rdata_q <= '0;
        endcase
      end else begin
        rdata_q <= '0;
      end
    end
  end

  assign pc = pc_q;
  assign fetch_addr = pc_q[IMPL_W-1:0];
  assign rdata = rdata_q;
  assign flags = flags_q;
  assign sfr_addr = full_addr;
  assign sfr_sel = dreq.valid && is_sfr && !is_ram;
  assign stack_full = (depth_q == 4'(STACK_DEPTH));

  // Program counter and return stack
  int_vector_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    int_take |=> pc_q == INT_VEC) else $error("interrupt did not vector");
  pc_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pc_op == BMM_PC_NEXT && !int_take && !(dreq.valid && dreq.write))
    |=> pc_q == $past(pc_q) + 13'h0001) else $error("pc did not step");
  pc_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dreq.valid && dreq.write && is_sfr && full_addr[6:0] == OFS_PCL && !int_take)
    |=> pc_q == {$past(program_counter_high_latch_q), $past(dreq.wdata)}) else $error("pc low write did not load");
  fetch_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pc_op == BMM_PC_JUMP && !int_take && !(dreq.valid && dreq.write))
    |=> fetch_addr == $past(pc_target[IMPL_W-1:0])) else $error("fetch not folded");
  call_return_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pc_op == BMM_PC_CALL && !int_take && !(dreq.valid && dreq.write)) ##1
    (pc_op == BMM_PC_RET && !int_take && !(dreq.valid && dreq.write))
    |=> pc_q == $past(pc_q, 2) + 13'h0001) else $error("return address wrong");
  stack_fill_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (depth_q == 4'(STACK_DEPTH - 1) && pc_op == BMM_PC_CALL && !int_take)
    |=> stack_full) else $error("stack not full after eighth push");

  // Data address decoding
  sfr_region_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (full_addr[6:0] <= SFR_TOP) |-> !is_ram) else $error("sfr region mapped as ram");
  sfr_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dreq.valid && full_addr[6:0] <= SFR_TOP) |-> sfr_sel) else $error("register access not selected");
  ram_bank0_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (full_addr >= RAM0_LO && full_addr <= RAM0_HI) |-> is_ram && ram_idx == full_addr[6:0])
    else $error("bank zero ram index wrong");
  ram_bank1_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (full_addr >= RAM1_LO && full_addr <= RAM1_HI) |-> is_ram && {1'b0, ram_idx} < RAM0_LO)
    else $error("bank one ram overlaps bank zero");
  mirror_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (full_addr >= MIR_LO) |-> ram_idx == full_addr[6:0] && is_ram) else $error("mirror bad");
  unimpl_gap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (full_addr > RAM1_HI && full_addr < MIR_LO) |-> !is_ram && !sfr_sel) else $error("gap location mapped");
  bank_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!dreq.indirect && dreq.addr != OFS_INDIRECT_DATA_PORT) |-> full_addr[7] == flags_q[BANK_BIT])
    else $error("bank bit not used");
  flags_bank_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dreq.valid && dreq.write && !dreq.indirect && dreq.addr == OFS_FLAGS)
    |=> flags_q[BANK_BIT] == $past(dreq.wdata[BANK_BIT])) else $error("bank bit not written");
  indirect_ptr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dreq.indirect || dreq.addr == OFS_INDIRECT_DATA_PORT) |-> full_addr == ptr_q) else $error("pointer not used");
  ptr_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dreq.valid && dreq.write && is_sfr && full_addr[6:0] == OFS_PTR)
    |=> ptr_q == $past(dreq.wdata)) else $error("pointer write lost");

  // Read data
  unimpl_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dreq.valid && !dreq.write && !is_ram && !is_sfr) |=> rdata_q == 8'h00)
    else $error("unimplemented read nonzero");
  ram_readback_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dreq.valid && dreq.write && is_ram) ##1 (dreq.valid && !dreq.write && is_ram
    && ram_idx == $past(ram_idx)) |=> rdata_q == $past(dreq.wdata, 2))
    else $error("ram readback wrong");
endmodule // bmm_top

// ### test/bmm_core_model.sv
// Core-side model issuing program counter and data requests
`timescale 1ns/1ns
module bmm_core_model (
  input wire logic sys_clk, // Core clock
  output bmm_pkg::bmm_pc_op_t pc_op, // Program counter operation
  output logic [bmm_pkg::PC_W-1:0] pc_target, // Jump or call target
  output logic int_take, // Interrupt accepted
  output bmm_pkg::bmm_dreq_t dreq // Data access request
);
  import bmm_pkg::*;
  initial begin
    pc_op = BMM_PC_NEXT;
    pc_target = 13'h0000;
    int_take = 1'b0;
    dreq = '0;
  end
  // Called at a falling edge; the request is taken at the next rising edge and stands
  // until the following call replaces it at the next falling edge
  task automatic issue(input bmm_pc_op_t op, input logic [12:0] tgt, input logic intr, input bmm_dreq_t rq);
    bmm_dreq_t r;
    r = rq;
    if (rq.write && rq.addr == OFS_FLAGS) r.wdata[7:6] = 2'b00;
    pc_op = op;
    pc_target = tgt;
    int_take = intr;
    dreq = r;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
endmodule // bmm_core_model

// ### test/testbench.sv
// Self-checking bench for the banked memory map
`timescale 1ns/1ns
module testbench;
  import bmm_pkg::*;
  logic sys_clk, rst_n, int_take, sfr_sel, stack_full, bank;
  bmm_pc_op_t pc_op;
  bmm_dreq_t dreq;
  logic [12:0] pc_target, pc, ep, t;
  logic [10:0] fetch_addr;
  logic [7:0] rdata, flags, sfr_addr, ptr, v;
  logic [12:0] ret_q [$];
  int n_fail, checks;
  int mem [256];
  bmm_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .pc_op(pc_op), .pc_target(pc_target), .int_take(int_take),
    .dreq(dreq), .pc(pc), .fetch_addr(fetch_addr), .rdata(rdata), .flags(flags), .sfr_addr(sfr_addr),
    .sfr_sel(sfr_sel), .stack_full(stack_full));
  bmm_core_model core (.sys_clk(sys_clk), .pc_op(pc_op), .pc_target(pc_target), .int_take(int_take), .dreq(dreq));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic pc_do(input bmm_pc_op_t op, input logic [12:0] tgt, input logic intr);
    core.issue(op, tgt, intr, '0);
    if (intr || op == BMM_PC_CALL) ret_q.push_back(ep + 13'h0001);
    if (intr) ep = INT_VEC;
    else if (op == BMM_PC_RET) ep = ret_q.pop_back();
    else ep = tgt;
    chk_pc(pc, ep);
    chk_pc({2'b00, fetch_addr}, {2'b00, ep[10:0]});
  endtask
  task automatic dacc(input logic wr, input logic ind, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] fa;
    logic [7:0] f;
    fa = (ind || a == OFS_INDIRECT_DATA_PORT) ? ptr : {bank, a};
    f = fa;
    if (f >= MIR_LO) f = f - MIR_OFS;
    core.issue(BMM_PC_NEXT, 13'h0000, 1'b0, {1'b1, wr, ind, a, d});
    chk_byte(sfr_addr, fa);
    chk_byte({7'h00, sfr_sel}, {7'h00, (fa[6:0] <= SFR_TOP)});
    if (wr && f >= RAM0_LO && (f <= RAM0_HI || (f >= RAM1_LO && f <= RAM1_HI))) mem[f] = d;
    else if (!wr) chk_byte(rdata, mem[f][7:0]);
  endtask
  task automatic set_bank(input logic b);
    core.issue(BMM_PC_NEXT, 13'h0000, 1'b0, {3'b110, OFS_FLAGS, 2'b00, b, 5'h00});
    bank = b;
    chk_byte(flags, {2'b00, b, 5'h18});
  endtask
  initial begin
    #2000000;
    n_fail++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    n_fail = 0;
    checks = 0;
    ep = RESET_VEC;
    bank = 1'b0;
    ptr = 8'h00;
    foreach (mem[i]) mem[i] = 0;
    void'($urandom(32'h363baecb));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_pc(pc, RESET_VEC);
    chk_byte(flags, FLAGS_RST);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) pc_do(BMM_PC_JUMP, 13'($urandom), 1'b0);
    pc_do(BMM_PC_CALL, 13'h1100, 1'b0);
    pc_do(BMM_PC_RET, 13'h0000, 1'b0);
    for (int k = 1; k <= 8; k++) begin
      pc_do(BMM_PC_CALL, 13'(k * 16), 1'b0);
      chk_pc({12'h000, stack_full}, {12'h000, k == 8});
    end
    for (int k = 0; k < 8; k++) pc_do(BMM_PC_RET, 13'h0000, 1'b0);
    pc_do(BMM_PC_NEXT, 13'h0000, 1'b1);
    pc_do(BMM_PC_RET, 13'h0000, 1'b0);
    for (int i = 0; i < 24; i++) begin
      set_bank(1'($urandom));
      t = 13'(7'h20 + $urandom % 96);
      v = 8'($urandom);
      dacc(1'b1, 1'b0, t[6:0], v);
      dacc(1'b0, 1'b0, t[6:0], 8'h00);
    end
    set_bank(1'b0);
    dacc(1'b1, 1'b0, 7'h75, 8'h5A);
    dacc(1'b0, 1'b0, 7'h05, 8'h00);
    set_bank(1'b1);
    dacc(1'b0, 1'b0, 7'h75, 8'h00);
    dacc(1'b0, 1'b0, 7'h50, 8'h00);
    core.issue(BMM_PC_NEXT, 13'h0000, 1'b0, {3'b110, OFS_PTR, 8'hA7});
    ptr = 8'hA7;
    dacc(1'b1, 1'b1, 7'h00, 8'hC3);
    dacc(1'b0, 1'b0, 7'h27, 8'h00);
    core.issue(BMM_PC_NEXT, 13'h0000, 1'b0, {3'b110, OFS_PROGRAM_COUNTER_HIGH_LATCH, 8'h15});
    core.issue(BMM_PC_NEXT, 13'h0000, 1'b0, {3'b110, OFS_PCL, 8'h3C});
    chk_pc(pc, 13'h153C);
    chk_pc({2'b00, fetch_addr}, 13'h053C);
    conclude();
  end
endmodule // testbench
